//--- rtl/ext_bus_pkg.sv
package ext_bus_pkg;

    // ****************************************************************
    // register map (byte addresses on apb)
    // ****************************************************************
    localparam logic [11:0] PTR_SELECT_INDEX = 12'h092;
    localparam logic [11:0] PTR_SELECT_ADDR = 12'(PTR_SELECT_INDEX * 4);
    localparam logic [11:0] PTR_LOW_ADDR = 12'h000;
    localparam logic [11:0] PTR_HIGH_ADDR = 12'h004;
    localparam logic [11:0] PORT0_LATCH_ADDR = 12'h008;
    localparam logic [11:0] PORT2_LATCH_ADDR = 12'h00C;
    localparam logic [11:0] PROG_COUNTER_ADDR = 12'h010;
    localparam logic [11:0] COMMAND_ADDR = 12'h014;
    localparam logic [11:0] STATUS_ADDR = 12'h018;

    // ****************************************************************
    // reset values and fields
    // ****************************************************************
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
    localparam logic [7:0] PORT0_ACCESS_FILL = 8'hFF;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] INTERNAL_PROG_TOP = 16'h7FFF;
    localparam logic [15:0] PC_FETCH_STEP = 16'h0002;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_RI_LSB = 8;
    localparam int CMD_WDATA_LSB = 16;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int POINTER_COUNT = 8;

    // ****************************************************************
    // cycle timing in oscillator periods (one clk each)
    // ****************************************************************
    localparam logic [2:0] DATA_CYCLE_LEN = 3'h6;
    localparam logic [2:0] FETCH_CYCLE_LEN = 3'h3;
    localparam logic [2:0] PH_ADDR_HOLD = 3'h1;
    localparam logic [2:0] PH_DATA_STROBE_ON = 3'h2;
    localparam logic [2:0] PH_DATA_STROBE_LAST = 3'h4;
    localparam logic [2:0] PH_FETCH_STROBE_LAST = 3'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_NONE,
        OP_FETCH,
        OP_READ_PTR,
        OP_WRITE_PTR,
        OP_READ_RI,
        OP_WRITE_RI
    } cmd_op_type;

    typedef enum {
        SEQ_IDLE,
        SEQ_FETCH,
        SEQ_DATA
    } seq_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_resp_type;

    typedef struct packed {
        logic ale;
        logic prog_read_strobe_n;
        logic data_read_n;
        logic data_write_n;
        logic [7:0] port0_out;
        logic port0_oe_n;
        logic [7:0] port2_out;
    } ext_pins_type;

    typedef struct packed {
        logic wr_lo;
        logic wr_hi;
        logic [2:0] wr_idx;
        logic [7:0] wr_data;
        logic [2:0] rd_idx;
    } ptr_mem_req_type;

endpackage : ext_bus_pkg

//--- rtl/pointer_bank.sv
module pointer_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // access
    input wire ext_bus_pkg::ptr_mem_req_type req,
    output logic [15:0] rd_data
);
    import ext_bus_pkg::*;

    typedef struct packed {
        logic [POINTER_COUNT-1:0][15:0] ptr;
        logic [15:0] rd;
    } bank_type;

    bank_type bank_reg;
    bank_type bank_next;

    // ****************************************************************
    // byte writes to one pointer, others keep their value
    // ****************************************************************
    always_comb begin
        bank_next = bank_reg;
        for (int i = 0; i < POINTER_COUNT; i++) begin
            if (req.wr_lo && req.wr_idx == 3'(i)) begin
                bank_next.ptr[i][7:0] = req.wr_data;
            end
            if (req.wr_hi && req.wr_idx == 3'(i)) begin
                bank_next.ptr[i][15:8] = req.wr_data;
            end
        end
        bank_next.rd = bank_reg.ptr[req.rd_idx];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bank_reg <= '0;
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign rd_data = bank_reg.rd;

endmodule : pointer_bank

//--- rtl/ext_bus_multi_pointer.sv
// Summary of operation
// - write byte driven around data write strobe
// - read byte sampled before read strobe release
// - external fetch when select low or pc>7FFF
// - port2 all address, latch left untouched
// - port2 shows pc, pointer or latch
// - no program strobe for internal fetch
// - two program strobes per instruction cycle
// - data read cycle lasts six periods
// - program fetch cycle lasts three periods
// - eight 16-bit pointers, one active
// - 3-bit select chooses the active pointer
// - select resets to pointer zero
// - active pointer seen as two bytes
// - port0 multiplexes address and data, driven
// - external access fills port0 latch with ones
// - register-indirect move keeps port2 latch out
//
// The APB slave port was left to the implementer.
module ext_bus_multi_pointer (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire ext_bus_pkg::apb_req_type apb_req,
    output ext_bus_pkg::apb_resp_type apb_resp,
    // external bus pins
    input wire logic external_access_select_n,
    input wire logic [7:0] port0_in,
    output ext_bus_pkg::ext_pins_type pins
);
    import ext_bus_pkg::*;

    typedef struct packed {
        seq_state_type st;
        logic [2:0] ph;
        cmd_op_type op;
        logic second;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [2:0] sel;
        logic [7:0] p0_latch;
        logic [7:0] p2_latch;
        logic [15:0] pc;
        ext_pins_type pins;
    } core_type;

    core_type core_reg;
    core_type core_next;
    logic [15:0] active_ptr;
    ptr_mem_req_type mem_req;
    logic apb_access;
    logic apb_wr;
    logic busy;
    logic cmd_hit;
    logic ext_exec;
    logic mapped;
    cmd_op_type cmd_op;

    // ****************************************************************
    // pointer bank
    // ****************************************************************
    pointer_bank u_pointer_bank (
        .clk(clk),
        .rstn(rstn),
        .req(mem_req),
        .rd_data(active_ptr)
    );

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign apb_access = apb_req.psel && apb_req.penable;
    assign busy = core_reg.st != SEQ_IDLE;
    assign cmd_hit = apb_req.paddr == COMMAND_ADDR;
    assign ext_exec = !external_access_select_n || core_reg.pc > INTERNAL_PROG_TOP;
    assign apb_wr = apb_access && apb_req.pwrite && apb_resp.pready;
    assign cmd_op = cmd_op_type'(apb_req.pwdata[CMD_OP_LSB +: 3]);

    always_comb begin
        unique case (apb_req.paddr)
            PTR_SELECT_ADDR, PTR_LOW_ADDR, PTR_HIGH_ADDR, PORT0_LATCH_ADDR,
            PORT2_LATCH_ADDR, PROG_COUNTER_ADDR, COMMAND_ADDR, STATUS_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        apb_resp.pready = !(apb_req.pwrite && cmd_hit && busy);
        apb_resp.pslverr = apb_access && !mapped;
        apb_resp.prdata = '0;
        if (apb_access && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                PTR_SELECT_ADDR: apb_resp.prdata[2:0] = core_reg.sel;
                PTR_LOW_ADDR: apb_resp.prdata[7:0] = active_ptr[7:0];
                PTR_HIGH_ADDR: apb_resp.prdata[7:0] = active_ptr[15:8];
                PORT0_LATCH_ADDR: apb_resp.prdata[7:0] = core_reg.p0_latch;
                PORT2_LATCH_ADDR: apb_resp.prdata[7:0] = core_reg.p2_latch;
                PROG_COUNTER_ADDR: apb_resp.prdata[15:0] = core_reg.pc;
                STATUS_ADDR: begin
                    apb_resp.prdata[7:0] = core_reg.rdata;
                    apb_resp.prdata[STATUS_BUSY_BIT] = busy;
                end
                default: apb_resp.prdata = '0;
            endcase
        end
    end

    // ****************************************************************
    // pointer writes go to the selected pointer
    // ****************************************************************
    always_comb begin
        mem_req.wr_lo = apb_wr && apb_req.paddr == PTR_LOW_ADDR;
        mem_req.wr_hi = apb_wr && apb_req.paddr == PTR_HIGH_ADDR;
        mem_req.wr_idx = core_reg.sel;
        mem_req.wr_data = apb_req.pwdata[7:0];
        mem_req.rd_idx = core_reg.sel;
    end

    // ****************************************************************
    // register writes and bus sequencer
    // ****************************************************************
    always_comb begin
        core_next = core_reg;
        if (apb_wr) begin
            unique case (apb_req.paddr)
                PTR_SELECT_ADDR: core_next.sel = apb_req.pwdata[2:0];
                PORT0_LATCH_ADDR: core_next.p0_latch = apb_req.pwdata[7:0];
                PORT2_LATCH_ADDR: core_next.p2_latch = apb_req.pwdata[7:0];
                PROG_COUNTER_ADDR: core_next.pc = apb_req.pwdata[15:0];
                default: core_next.sel = core_reg.sel;
            endcase
        end
        unique case (core_reg.st)
            SEQ_IDLE: begin
                if (apb_wr && cmd_hit) begin
                    core_next.op = cmd_op;
                    core_next.ph = '0;
                    core_next.second = 1'b0;
                    core_next.wdata = apb_req.pwdata[CMD_WDATA_LSB +: 8];
                    unique case (cmd_op)
                        OP_FETCH: begin
                            if (ext_exec) begin
                                core_next.st = SEQ_FETCH;
                                core_next.addr = core_reg.pc;
                                core_next.p0_latch = PORT0_ACCESS_FILL;
                            end else begin
                                core_next.pc = core_reg.pc + PC_FETCH_STEP;
                            end
                        end
                        OP_READ_PTR, OP_WRITE_PTR: begin
                            core_next.st = SEQ_DATA;
                            core_next.addr = active_ptr;
                            core_next.p0_latch = PORT0_ACCESS_FILL;
                        end
                        OP_READ_RI, OP_WRITE_RI: begin
                            core_next.st = SEQ_DATA;
                            core_next.addr = {core_reg.p2_latch, apb_req.pwdata[CMD_RI_LSB +: 8]};
                            core_next.p0_latch = PORT0_ACCESS_FILL;
                        end
                        default: core_next.st = SEQ_IDLE;
                    endcase
                end
            end
            SEQ_FETCH: begin
                core_next.ph = core_reg.ph + 3'h1;
                if (core_reg.ph == FETCH_CYCLE_LEN - 3'h1) begin
                    core_next.ph = '0;
                    core_next.addr = core_reg.addr + 16'h0001;
                    core_next.second = 1'b1;
                    if (core_reg.second) begin
                        core_next.st = SEQ_IDLE;
                        core_next.pc = core_reg.pc + PC_FETCH_STEP;
                    end
                end
            end
            SEQ_DATA: begin
                core_next.ph = core_reg.ph + 3'h1;
                if (core_reg.ph == PH_DATA_STROBE_LAST
                        && (core_reg.op == OP_READ_PTR || core_reg.op == OP_READ_RI)) begin
                    core_next.rdata = port0_in;
                end
                if (core_reg.ph == DATA_CYCLE_LEN - 3'h1) begin
                    core_next.st = SEQ_IDLE;
                    core_next.ph = '0;
                end
            end
        endcase

        // ************************************************************
        // pin values for the coming period
        // ************************************************************
        core_next.pins.ale = 1'b0;
        core_next.pins.prog_read_strobe_n = 1'b1;
        core_next.pins.data_read_n = 1'b1;
        core_next.pins.data_write_n = 1'b1;
        core_next.pins.port0_oe_n = 1'b1;
        core_next.pins.port0_out = core_next.p0_latch;
        core_next.pins.port2_out = ext_exec ? core_next.pc[15:8] : core_next.p2_latch;
        unique case (core_next.st)
            SEQ_FETCH: begin
                core_next.pins.port2_out = core_next.addr[15:8];
                if (core_next.ph == '0) begin
                    core_next.pins.ale = 1'b1;
                    core_next.pins.port0_out = core_next.addr[7:0];
                    core_next.pins.port0_oe_n = 1'b0;
                end else begin
                    core_next.pins.prog_read_strobe_n = 1'b0;
                end
            end
            SEQ_DATA: begin
                if (core_next.op == OP_READ_PTR || core_next.op == OP_WRITE_PTR) begin
                    core_next.pins.port2_out = core_next.addr[15:8];
                end else begin
                    core_next.pins.port2_out = core_next.p2_latch;
                end
                if (core_next.ph <= PH_ADDR_HOLD) begin
                    core_next.pins.ale = core_next.ph == '0;
                    core_next.pins.port0_out = core_next.addr[7:0];
                    core_next.pins.port0_oe_n = 1'b0;
                end else if (core_next.op == OP_WRITE_PTR || core_next.op == OP_WRITE_RI) begin
                    core_next.pins.port0_out = core_next.wdata;
                    core_next.pins.port0_oe_n = 1'b0;
                    core_next.pins.data_write_n = !(core_next.ph > PH_DATA_STROBE_ON
                        && core_next.ph <= PH_DATA_STROBE_LAST);
                end else begin
                    core_next.pins.data_read_n = !(core_next.ph >= PH_DATA_STROBE_ON
                        && core_next.ph <= PH_DATA_STROBE_LAST);
                end
            end
            SEQ_IDLE: core_next.pins.ale = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            core_reg.st <= SEQ_IDLE;
            core_reg.ph <= '0;
            core_reg.op <= OP_NONE;
            core_reg.second <= 1'b0;
            core_reg.addr <= '0;
            core_reg.wdata <= '0;
            core_reg.rdata <= '0;
            core_reg.sel <= SELECT_RESET;
            core_reg.p0_latch <= PORT_LATCH_RESET;
            core_reg.p2_latch <= PORT_LATCH_RESET;
            core_reg.pc <= PC_RESET;
            core_reg.pins.ale <= 1'b0;
            core_reg.pins.prog_read_strobe_n <= 1'b1;
            core_reg.pins.data_read_n <= 1'b1;
            core_reg.pins.data_write_n <= 1'b1;
            core_reg.pins.port0_out <= PORT_LATCH_RESET;
            core_reg.pins.port0_oe_n <= 1'b1;
            core_reg.pins.port2_out <= PORT_LATCH_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    assign pins = core_reg.pins;

endmodule : ext_bus_multi_pointer

//--- test/ext_bus_multi_pointer_assertions.sv
module ext_bus_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire ext_bus_pkg::apb_req_type apb_req,
    input wire ext_bus_pkg::apb_resp_type apb_resp,
    // external bus
    input wire logic external_access_select_n,
    input wire logic [7:0] port0_in,
    input wire ext_bus_pkg::ext_pins_type pins
);
    import ext_bus_pkg::*;
    // ********
    // bus timing and apb error response properties
    // ********
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_ale_pulse;
        pins.ale |-> !pins.port0_oe_n ##1 !pins.ale;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too long");
    property p_read_len;
        $fell(pins.data_read_n) |-> $past(pins.ale, 2) ##0
            !pins.data_read_n[*3] ##1 pins.data_read_n;
    endproperty
    a_read_len: assert property (p_read_len) else $error("data read cycle length");
    property p_read_float;
        !pins.data_read_n |-> pins.port0_oe_n;
    endproperty
    a_read_float: assert property (p_read_float) else $error("port0 driven in read");
    property p_fetch_len;
        $fell(pins.prog_read_strobe_n) |-> $past(pins.ale) ##0
            !pins.prog_read_strobe_n[*2] ##1 pins.prog_read_strobe_n;
    endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch cycle length");
    property p_write_hold;
        $fell(pins.data_write_n) |-> $past(pins.port0_oe_n) == 1'b0 ##0
            (!pins.data_write_n && !pins.port0_oe_n && $stable(pins.port0_out))[*2]
            ##1 (pins.data_write_n && !pins.port0_oe_n && $stable(pins.port0_out));
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write data not held");
    property p_strobe_excl;
        !pins.prog_read_strobe_n |-> pins.data_read_n && pins.data_write_n;
    endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("strobes overlap");
    property p_port2_hold;
        pins.ale |=> $stable(pins.port2_out)[*2];
    endproperty
    a_port2_hold: assert property (p_port2_hold) else $error("port2 moved");
    property p_unmapped;
        apb_req.psel && apb_req.penable && apb_resp.pslverr |->
            apb_resp.pready && apb_resp.prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("error access returned data");
endmodule : ext_bus_checker

bind ext_bus_multi_pointer ext_bus_checker u_checker (
    .clk(clk),
    .rstn(rstn),
    .apb_req(apb_req),
    .apb_resp(apb_resp),
    .external_access_select_n(external_access_select_n),
    .port0_in(port0_in),
    .pins(pins)
);

//--- test/ext_mem_model.sv
module ext_mem_model (
    // clock
    input wire logic clk,
    // external bus
    input wire ext_bus_pkg::ext_pins_type pins,
    output logic [7:0] port0_in,
    // observation
    output logic [15:0] last_addr,
    output int fetches
);
    timeunit 1ns;
    timeprecision 100ps;
    import ext_bus_pkg::*;
    logic [7:0] mem [logic [15:0]];
    logic read_any_n;
    logic prog_prev = 1'b1;
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8];
    endfunction : mem_byte
    // shared memory: either active-low strobe reads
    assign read_any_n = pins.prog_read_strobe_n & pins.data_read_n;
    initial begin
        port0_in = 8'h00;
        last_addr = 16'h0000;
        fetches = 0;
    end
    always @(posedge clk) begin
        prog_prev <= pins.prog_read_strobe_n;
        if (pins.ale) begin
            last_addr <= {pins.port2_out, pins.port0_out};
        end
        if (!pins.data_write_n) begin
            mem[last_addr] = pins.port0_out;
        end
        if (!read_any_n) begin
            port0_in <= mem_byte(last_addr);
        end else begin
            port0_in <= ~port0_in;
        end
        if (prog_prev && !pins.prog_read_strobe_n) begin
            fetches <= fetches + 1;
        end
    end
endmodule : ext_mem_model

//--- test/ext_bus_multi_pointer_bench.sv
module ext_bus_multi_pointer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ext_bus_pkg::*;
    localparam logic [15:0] PTR_VAL [8] = '{16'h1FFF, 16'h2FA0, 16'h0001, 16'hFFFE,
        16'h8000, 16'h7FFF, 16'hA55A, 16'h00FF};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_sel_n = 1'b1;
    apb_req_type req = '0;
    apb_resp_type resp;
    ext_pins_type pins;
    logic [7:0] p0_in;
    logic [15:0] last_addr;
    int fetches;
    int f0;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    always #2.5 clk = ~clk;
    ext_bus_multi_pointer DUT (
        .clk(clk),
        .rstn(rstn),
        .apb_req(req),
        .apb_resp(resp),
        .external_access_select_n(ext_sel_n),
        .port0_in(p0_in),
        .pins(pins)
    );
    ext_mem_model u_mem (
        .clk(clk),
        .pins(pins),
        .port0_in(p0_in),
        .last_addr(last_addr),
        .fetches(fetches)
    );
    // ********
    // tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (resp.pready !== 1'b1 && n < 400) begin
            n++;
            @(posedge clk);
        end
        if (resp.pready !== 1'b1) begin
            n_fail++;
            $display("BAD %0t no ready on bus", $time);
        end
        rd = resp.prdata;
        er = resp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    task automatic cmd(input cmd_op_type op, input logic [7:0] ad, input logic [7:0] wb);
        int n;
        n = 0;
        apb(1'b1, COMMAND_ADDR, {8'h00, wb, ad, 5'h00, op});
        do begin
            apb(1'b0, STATUS_ADDR, 32'h0);
            n++;
        end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 50);
        if (rd[STATUS_BUSY_BIT] !== 1'b0) begin
            n_fail++;
            $display("BAD %0t command never finished", $time);
        end
    endtask : cmd
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check({pins.ale, pins.prog_read_strobe_n, pins.data_read_n, pins.data_write_n,
            pins.port0_oe_n, pins.port0_out}, 13'h0FFF);
        apb(1'b0, PTR_SELECT_ADDR, 32'h0);
        check(rd[2:0], SELECT_RESET);
        apb(1'b0, PTR_LOW_ADDR, 32'h0);
        check(rd[7:0], 8'h00);
        for (int i = 0; i < POINTER_COUNT; i++) begin
            apb(1'b1, PTR_SELECT_ADDR, 32'(i));
            apb(1'b1, PTR_LOW_ADDR, {24'h0, PTR_VAL[i][7:0]});
            apb(1'b1, PTR_HIGH_ADDR, {24'h0, PTR_VAL[i][15:8]});
        end
        for (int i = POINTER_COUNT - 1; i >= 0; i--) begin
            apb(1'b1, PTR_SELECT_ADDR, 32'(i));
            apb(1'b0, PTR_LOW_ADDR, 32'h0);
            check(rd[7:0], PTR_VAL[i][7:0]);
            apb(1'b0, PTR_HIGH_ADDR, 32'h0);
            check(rd[7:0], PTR_VAL[i][15:8]);
        end
        apb(1'b1, PTR_SELECT_ADDR, 32'h1);
        apb(1'b1, PORT0_LATCH_ADDR, 32'h5A);
        cmd(OP_WRITE_PTR, 8'h00, 8'hC3);
        check(last_addr, PTR_VAL[1]);
        cmd(OP_READ_PTR, 8'h00, 8'h00);
        check(rd[7:0], 8'hC3);
        apb(1'b0, PORT0_LATCH_ADDR, 32'h0);
        check(rd[7:0], PORT0_ACCESS_FILL);
        apb(1'b1, PORT2_LATCH_ADDR, 32'h3C);
        cmd(OP_WRITE_RI, 8'h17, 8'h96);
        check(last_addr, 16'h3C17);
        cmd(OP_READ_RI, 8'h17, 8'h00);
        check(rd[7:0], 8'h96);
        apb(1'b1, COMMAND_ADDR, {8'h00, 8'h5E, 8'h18, 5'h00, OP_WRITE_RI});
        cmd(OP_READ_RI, 8'h18, 8'h00);
        check(rd[7:0], 8'h5E);
        apb(1'b0, PORT2_LATCH_ADDR, 32'h0);
        check(rd[7:0], 8'h3C);
        apb(1'b1, PROG_COUNTER_ADDR, 32'h0100);
        f0 = fetches;
        cmd(OP_FETCH, 8'h00, 8'h00);
        check(32'(fetches - f0), 32'h0);
        apb(1'b0, PROG_COUNTER_ADDR, 32'h0);
        check(rd[15:0], 16'h0100 + PC_FETCH_STEP);
        apb(1'b1, PROG_COUNTER_ADDR, 32'h8000);
        f0 = fetches;
        cmd(OP_FETCH, 8'h00, 8'h00);
        check(32'(fetches - f0), 32'h2);
        check(last_addr, 16'h8001);
        ext_sel_n <= 1'b0;
        apb(1'b1, PROG_COUNTER_ADDR, 32'h0010);
        f0 = fetches;
        cmd(OP_FETCH, 8'h00, 8'h00);
        check(32'(fetches - f0), 32'h2);
        check(last_addr, 16'h0011);
        apb(1'b0, 12'h0FC, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        final_report;
    end
endmodule : ext_bus_multi_pointer_bench
